// ---- logic/vstp_chan.sv ----
/*
  One processing channel: signed offset around mid-code, then gain, both clipped.
  Assumes the sample is an unsigned 16-bit code; purely combinational.
*/
module vstp_chan
  import vstp_pkg::*;
(
  input  wire logic [WORD_W-1:0] sample,
  input  wire logic [OFFS_W-1:0] offset,
  input  wire logic [GAIN_W-1:0] gain,
  output logic [WORD_W-1:0]      result
);
  wire logic [8:0]          off_c  = {1'b0, offset} - OFFS_MID;
  wire logic signed [18:0]  pre    = $signed({3'b000, sample}) + $signed({{4{off_c[8]}}, off_c, 6'b00_0000});
  wire logic [WORD_W-1:0]   clip   = pre[18] ? 16'h0000 : (|pre[17:16] ? 16'hffff : pre[15:0]);
  wire logic [24:0]         prod   = clip * gain;
  wire logic [16:0]         scaled = prod[24:GAIN_SHIFT];

  assign result = scaled[16] ? 16'hffff : scaled[15:0];
endmodule

// ---- logic/vstp_fifo.sv ----
/*
  Flip-flop FIFO with valid/ready on both sides and a fill count.
  Assumes a single clock and an active-low asynchronous reset.
*/
module vstp_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 clr,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire logic [W-1:0]         in_data,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic [W-1:0]              out_data,
  output logic [$clog2(D):0]        count
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW:0]   wp_q;
  logic [AW:0]   rp_q;
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;

  assign count     = wp_q - rp_q;
  assign in_ready  = (count != (AW+1)'(D));
  assign out_valid = (count != '0);
  assign out_data  = mem_q[rp_q[AW-1:0]];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (clr) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop)  rp_q <= rp_q + 1'b1;
    end
  end

  always_ff @(posedge pclk) begin
    if (push) mem_q[wp_q[AW-1:0]] <= in_data;
  end
endmodule

// ---- logic/vstp_pkg.sv ----
/*
  Shared constants of the video sample timing and power-on reset block:
  register offsets, field positions, reset values, mode codes and timing counts.
  Assumes a 20 MHz pclk that also serves as the master sampling clock.
*/
package vstp_pkg;
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          LAT_PERIODS   = 7;
  localparam int          WORD_W        = 16;
  localparam int          BYTE_W        = 8;
  localparam int          OFFS_W        = 8;
  localparam int          GAIN_W        = 9;
  localparam int          NUM_CH        = 3;
  localparam int          FIFO_DEPTH    = 16;
  // Minimum pixel periods per mode, in ns, as tenths to keep 83.3 and 41.6 exact
  localparam int          PIX3_MIN_NS10 = 1250;
  localparam int          PIX2_MIN_NS10 = 833;
  localparam int          PIX1_MIN_NS10 = 416;
  localparam int          PIX3_MIN_CYC  = (PIX3_MIN_NS10 + CLK_PERIOD_NS * 10 - 1) / (CLK_PERIOD_NS * 10);
  localparam int          PIX2_MIN_CYC  = (PIX2_MIN_NS10 + CLK_PERIOD_NS * 10 - 1) / (CLK_PERIOD_NS * 10);
  localparam int          PIX1_MIN_CYC  = (PIX1_MIN_NS10 + CLK_PERIOD_NS * 10 - 1) / (CLK_PERIOD_NS * 10);

  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_SWRESET  = 8'h04;
  localparam logic [7:0]  ADDR_OFFS0    = 8'h08;
  localparam logic [7:0]  ADDR_GAIN0    = 8'h14;
  localparam logic [7:0]  ADDR_STATUS   = 8'h20;

  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_SEL_LSB  = 2;
  localparam int          CTRL_CDS_BIT  = 4;
  localparam int          CTRL_COMPAT   = 5;
  localparam int          CTRL_W        = 6;
  localparam logic [5:0]  CTRL_RST      = 6'h12;
  localparam logic [7:0]  OFFS_RST      = 8'h80;
  localparam logic [8:0]  GAIN_RST      = 9'h100;
  localparam logic [8:0]  OFFS_MID      = 9'h080;
  localparam int          OFFS_SHIFT    = 6;
  localparam int          GAIN_SHIFT    = 8;

  typedef enum logic [1:0] {
    VSTP_MONO  = 2'b00,
    VSTP_TWO   = 2'b01,
    VSTP_THREE = 2'b10
  } vstp_mode_t;

  typedef enum logic [1:0] {
    VSTP_SER_IDLE = 2'b00,
    VSTP_SER_HI   = 2'b01,
    VSTP_SER_LO   = 2'b10
  } vstp_ser_t;
endpackage

// ---- logic/vstp_top.sv ----
/*
  Sampling sequencer, output latency pipeline, byte serialiser and APB control
  registers of a three-channel image-sensor digitiser, held in reset by the
  internal power-on reset.
  Assumes strobes and sample codes are synchronous to pclk, which is the master clock.
*/
// The placing of the registers and the APB interface to the registers are this design's own decisions.
// Operation
// - Video strobe high connects video capacitors
// - Reset strobe high connects reset capacitors (here only while the CDS bit of the control register is set)
// - Data out seven periods after fall
// - Power-on reset holds logic, drops writes
// - Release leaves defaults, writes accepted
// - Sixteen-bit result sent as two bytes
// - Per-channel 8-bit offset, 9-bit gain
// - Simultaneous sampling, one to three channels
// - All configuration writable by the host
// - Compat bit selects older sampling timing
// - Compat: clock twice conversion rate
module vstp_top
  import vstp_pkg::*;
#(
  parameter int LAT   = LAT_PERIODS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              power_on_reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              video_sample_strobe,
  input  wire logic              reset_sample_strobe,
  input  wire logic [WORD_W-1:0] red_input,
  input  wire logic [WORD_W-1:0] green_input,
  input  wire logic [WORD_W-1:0] blue_input,
  output logic                   video_cap_en,
  output logic                   reset_cap_en,
  output logic [BYTE_W-1:0]      data_out,
  output logic                   data_valid,
  output logic                   data_hi,
  input  wire logic              data_ready
);
  import vstp_pkg::*;

  logic [CTRL_W-1:0]  ctrl_q;
  logic [OFFS_W-1:0]  offs_q [NUM_CH];
  logic [GAIN_W-1:0]  gain_q [NUM_CH];
  logic               overrun_q;
  logic [31:0]        prdata_q;
  logic               pready_q, pslverr_q;
  logic               vs_q, vcap_q, rcap_q, conv_en_q, leg_rs_q;
  logic [WORD_W-1:0]  samp_q [NUM_CH];
  logic [WORD_W-1:0]  pipe_w_q [LAT][NUM_CH];
  logic [1:0]         pipe_n_q [LAT];
  logic [LAT-1:0]     pipe_v_q;
  logic [WORD_W-1:0]  pend_q [NUM_CH];
  logic [1:0]         left_q, idx_q;
  vstp_ser_t          ser_q;
  logic [WORD_W-1:0]  word_q;
  logic [BYTE_W-1:0]  dout_q;
  logic               dval_q, dhi_q;

  // Register decode
  wire                setup    = psel & ~penable;
  wire                wr_acc   = psel & penable & pready_q & pwrite;
  wire                por_n    = power_on_reset_n;
  wire                wr_ok    = wr_acc & por_n & ~pslverr_q;
  wire                hit_ctrl = (paddr == ADDR_CTRL);
  wire                hit_swr  = (paddr == ADDR_SWRESET);
  wire                hit_stat = (paddr == ADDR_STATUS);
  wire logic [7:0]    offs_rel = paddr - ADDR_OFFS0;
  wire logic [7:0]    gain_rel = paddr - ADDR_GAIN0;
  wire                hit_offs = (paddr >= ADDR_OFFS0) && (offs_rel < 8'(4 * NUM_CH)) && (paddr[1:0] == 2'b00);
  wire                hit_gain = (paddr >= ADDR_GAIN0) && (gain_rel < 8'(4 * NUM_CH)) && (paddr[1:0] == 2'b00);
  wire logic [1:0]    offs_idx = offs_rel[3:2];
  wire logic [1:0]    gain_idx = gain_rel[3:2];
  wire                mapped   = hit_ctrl | hit_swr | hit_stat | hit_offs | hit_gain;
  wire                sw_reset = wr_ok & hit_swr;
  wire                cfg_clr  = ~por_n | sw_reset;

  wire vstp_mode_t    mode     = vstp_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
  wire logic [1:0]    mono_sel = ctrl_q[CTRL_SEL_LSB +: 2];
  wire                cds_en   = ctrl_q[CTRL_CDS_BIT];
  wire                compat   = ctrl_q[CTRL_COMPAT];
  wire logic [$clog2(DEPTH):0] f_count;

  wire logic [31:0]   rd_mux   = hit_ctrl ? 32'(ctrl_q) :
                                 hit_offs ? 32'(offs_q[offs_idx]) :
                                 hit_gain ? 32'(gain_q[gain_idx]) :
                                 hit_stat ? 32'({overrun_q, f_count, por_n}) : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) prdata_q <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
    end else if (cfg_clr) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ok && hit_ctrl) begin
      ctrl_q <= pwdata[CTRL_W-1:0];
    end
  end

  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_cfg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          offs_q[c] <= OFFS_RST;
          gain_q[c] <= GAIN_RST;
        end else if (cfg_clr) begin
          offs_q[c] <= OFFS_RST;
          gain_q[c] <= GAIN_RST;
        end else begin
          if (wr_ok && hit_offs && offs_idx == 2'(c)) offs_q[c] <= pwdata[OFFS_W-1:0];
          if (wr_ok && hit_gain && gain_idx == 2'(c)) gain_q[c] <= pwdata[GAIN_W-1:0];
        end
      end
    end
  endgenerate

  // Sampling sequencer
  wire                samp_tick = ~compat | conv_en_q;
  wire                vs_fall   = samp_tick & vs_q & ~video_sample_strobe;
  wire                rs_gate   = cds_en & reset_sample_strobe;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vs_q      <= 1'b0;
      conv_en_q <= 1'b0;
      vcap_q    <= 1'b0;
      rcap_q    <= 1'b0;
      leg_rs_q  <= 1'b0;
    end else if (!por_n) begin
      vs_q      <= 1'b0;
      conv_en_q <= 1'b0;
      vcap_q    <= 1'b0;
      rcap_q    <= 1'b0;
      leg_rs_q  <= 1'b0;
    end else begin
      conv_en_q <= compat ? ~conv_en_q : 1'b1;
      if (samp_tick) vs_q <= video_sample_strobe;
      vcap_q    <= video_sample_strobe;
      leg_rs_q  <= vs_fall & rs_gate;
      rcap_q    <= compat ? leg_rs_q : rs_gate;
    end
  end

  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_samp
      wire logic [WORD_W-1:0] raw = (c == 0) ? red_input : (c == 1) ? green_input : blue_input;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) samp_q[c] <= '0;
        else if (video_sample_strobe) samp_q[c] <= raw;
      end
    end
  endgenerate

  logic [WORD_W-1:0]  proc [NUM_CH];
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
      vstp_chan u_chan (
        .sample (samp_q[c]),
        .offset (offs_q[c]),
        .gain   (gain_q[c]),
        .result (proc[c])
      );
    end
  endgenerate

  // Words per pixel by mode
  wire logic [1:0]    n_words = (mode == VSTP_THREE) ? 2'd3 : (mode == VSTP_TWO) ? 2'd2 : 2'd1;
  wire logic [1:0]    first   = (mode == VSTP_MONO && mono_sel < 2'(NUM_CH)) ? mono_sel : 2'd0;

  // Latency pipeline
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe_v_q <= '0;
    end else if (!por_n) begin
      pipe_v_q <= '0;
    end else begin
      pipe_v_q <= {pipe_v_q[LAT-2:0], vs_fall};
    end
  end

  generate
    for (genvar s = 0; s < LAT; s++) begin : g_pipe
      always_ff @(posedge pclk) begin
        if (s == 0) begin
          pipe_n_q[s] <= n_words;
          for (int c = 0; c < NUM_CH; c++) pipe_w_q[s][c] <= proc[(32'(first) + c) % NUM_CH];
        end else begin
          pipe_n_q[s] <= pipe_n_q[s-1];
          pipe_w_q[s] <= pipe_w_q[s-1];
        end
      end
    end
  endgenerate

  // Word sequencer into the FIFO
  wire                pix_out  = pipe_v_q[LAT-1];
  wire                f_in_rdy;
  wire                f_push   = (left_q != 2'd0);
  wire                f_acc    = f_push & f_in_rdy;
  wire                load     = pix_out & (left_q == 2'd0);
  wire                ovr_set  = pix_out & (left_q != 2'd0);
  wire                ovr_clr  = wr_ok & hit_stat & pwdata[6];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_q    <= 2'd0;
      idx_q     <= 2'd0;
      overrun_q <= 1'b0;
    end else if (!por_n) begin
      left_q    <= 2'd0;
      idx_q     <= 2'd0;
      overrun_q <= 1'b0;
    end else begin
      if (load) begin
        left_q <= pipe_n_q[LAT-1];
        idx_q  <= 2'd0;
      end else if (f_acc) begin
        left_q <= left_q - 2'd1;
        idx_q  <= idx_q + 2'd1;
      end
      overrun_q <= ovr_set | (overrun_q & ~ovr_clr);
    end
  end

  always_ff @(posedge pclk) begin
    if (load) pend_q <= pipe_w_q[LAT-1];
  end

  wire                f_out_valid;
  wire logic [WORD_W-1:0] f_out_data;
  wire                f_pop = (ser_q == VSTP_SER_IDLE);

  vstp_fifo #(.W(WORD_W), .D(DEPTH)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .clr       (~por_n),
    .in_valid  (f_push),
    .in_ready  (f_in_rdy),
    .in_data   (pend_q[idx_q]),
    .out_valid (f_out_valid),
    .out_ready (f_pop),
    .out_data  (f_out_data),
    .count     (f_count)
  );

  // Byte serialiser: high byte first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_q  <= VSTP_SER_IDLE;
      word_q <= '0;
      dout_q <= '0;
      dval_q <= 1'b0;
      dhi_q  <= 1'b0;
    end else if (!por_n) begin
      ser_q  <= VSTP_SER_IDLE;
      dval_q <= 1'b0;
      dhi_q  <= 1'b0;
    end else begin
      case (ser_q)
        VSTP_SER_IDLE: if (f_out_valid) begin
          word_q <= f_out_data;
          dout_q <= f_out_data[15:8];
          dval_q <= 1'b1;
          dhi_q  <= 1'b1;
          ser_q  <= VSTP_SER_HI;
        end
        VSTP_SER_HI: if (data_ready) begin
          dout_q <= word_q[7:0];
          dhi_q  <= 1'b0;
          ser_q  <= VSTP_SER_LO;
        end
        VSTP_SER_LO: if (data_ready) begin
          dval_q <= 1'b0;
          ser_q  <= VSTP_SER_IDLE;
        end
        default: ser_q <= VSTP_SER_IDLE;
      endcase
    end
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign video_cap_en = vcap_q;
  assign reset_cap_en = rcap_q;
  assign data_out     = dout_q;
  assign data_valid   = dval_q;
  assign data_hi      = dhi_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_fall; vs_fall && por_n; endsequence
  sequence s_hold; por_n [*6]; endsequence

  property p_vid; por_n ##1 por_n && video_sample_strobe |=> vcap_q; endproperty
  a_vid: assert property (p_vid) else $error("video capture not enabled by strobe");
  property p_rst; por_n && !compat && rs_gate ##1 por_n |-> rcap_q; endproperty
  a_rst: assert property (p_rst) else $error("reset capture not enabled by strobe");
  property p_nocds; por_n && !cds_en && !leg_rs_q |=> !rcap_q; endproperty
  a_nocds: assert property (p_nocds) else $error("reset capture without cds");
  property p_lat; s_fall ##1 s_hold |=> pix_out; endproperty
  a_lat: assert property (p_lat) else $error("result not ready seven periods after strobe fall");
  property p_por; !por_n |=> ctrl_q == CTRL_RST && gain_q[0] == GAIN_RST && offs_q[2] == OFFS_RST; endproperty
  a_por: assert property (p_por) else $error("registers not held at default during power-on reset");
  property p_porwr; !por_n && wr_acc |=> ctrl_q == CTRL_RST; endproperty
  a_porwr: assert property (p_porwr) else $error("write accepted during power-on reset");
  property p_wr; por_n && wr_acc && hit_gain && !pslverr_q ##1 por_n |-> gain_q[$past(gain_idx)] == $past(pwdata[8:0]); endproperty
  a_wr: assert property (p_wr) else $error("gain write not taken after reset release");
  property p_ser; dval_q && dhi_q && data_ready && por_n ##1 por_n |-> dval_q && !dhi_q && dout_q == word_q[7:0]; endproperty
  a_ser: assert property (p_ser) else $error("low byte does not follow high byte");
  property p_words; load && mode == VSTP_THREE && pipe_n_q[LAT-1] == 2'd3 && por_n |=> left_q == 2'd3; endproperty
  a_words: assert property (p_words) else $error("three-channel pixel not three words");
  property p_compat; por_n && compat && !conv_en_q ##1 por_n |-> $stable(vs_q); endproperty
  a_compat: assert property (p_compat) else $error("strobe sampled off the conversion tick");
endmodule

// ---- tb/test_video_sample_timing_and_por.sv ----
/*
  Self-checking bench: APB host, byte sink and timing controller around the digitiser.
  Assumes the design answers APB with one access cycle and pixels arrive in R,G,B order.
*/
module test_video_sample_timing_and_por;
  timeunit 1ns;
  timeprecision 100ps;
  import vstp_pkg::*;
  localparam int LAT = LAT_PERIODS;
  typedef struct {logic [1:0] mode; logic [1:0] sel; logic [15:0] r, g, b;} vstp_row_t;
  logic              pclk, presetn, power_on_reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]        paddr, data_out;
  logic [31:0]       pwdata, prdata, d;
  logic              video_sample_strobe, reset_sample_strobe, video_cap_en, reset_cap_en;
  logic [15:0]       red_input, green_input, blue_input;
  logic              data_valid, data_hi, data_ready, e, vs_p, rs_p, got_hi;
  logic [7:0]        hi_b;
  logic [15:0]       exp_q[$];
  int                err_count, tests_run, cyc, lat_n;
  bit                stall, lat_on, compat, cds_on;
  vstp_row_t         rows[5] = '{'{VSTP_MONO, 2'd0, 16'h1234, 16'h5678, 16'h9abc},
                                 '{VSTP_MONO, 2'd1, 16'h0001, 16'hfffe, 16'h8000},
                                 '{VSTP_MONO, 2'd2, 16'h00ff, 16'hff00, 16'h0f0f},
                                 '{VSTP_TWO, 2'd0, 16'ha5a5, 16'h5a5a, 16'h3333},
                                 '{VSTP_THREE, 2'd0, 16'h0102, 16'h0304, 16'h0506}};

  vstp_top #(.LAT(LAT), .DEPTH(FIFO_DEPTH)) DUT (.pclk(pclk), .presetn(presetn),
    .power_on_reset_n(power_on_reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .video_sample_strobe(video_sample_strobe), .reset_sample_strobe(reset_sample_strobe),
    .red_input(red_input), .green_input(green_input), .blue_input(blue_input),
    .video_cap_en(video_cap_en), .reset_cap_en(reset_cap_en), .data_out(data_out),
    .data_valid(data_valid), .data_hi(data_hi), .data_ready(data_ready));
  vstp_timing_ctrl u_ctrl (.pclk(pclk), .video_sample_strobe(video_sample_strobe),
    .reset_sample_strobe(reset_sample_strobe), .red_input(red_input), .green_input(green_input),
    .blue_input(blue_input));

  always #25 pclk = ~pclk;

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(n < 50, "no ready");
  endtask
  function automatic logic [15:0] chan(input logic [15:0] s, input logic [7:0] o, input logic [8:0] g);
    logic signed [19:0] a;
    logic [25:0]        m;
    a = $signed({4'h0, s}) + ($signed({1'b0, o}) - 20'sd128) * 20'sd64;
    if (a < 0) a = 20'sd0;
    else if (a > 20'sd65535) a = 20'sd65535;
    m = (a[15:0] * g) >> 8;
    return (m > 26'h00ffff) ? 16'hffff : m[15:0];
  endfunction
  task automatic push_px(input logic [1:0] mode, input logic [1:0] sel, input logic [15:0] w0, w1, w2);
    if (mode == VSTP_MONO) exp_q.push_back(sel == 2'd0 ? w0 : sel == 2'd1 ? w1 : w2);
    else exp_q.push_back(w0);
    if (mode != VSTP_MONO) exp_q.push_back(w1);
    if (mode == VSTP_THREE) exp_q.push_back(w2);
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk(exp_q.size() == 0 && !got_hi, "missing words");
    repeat (4) @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    cyc++;
    data_ready <= !stall && (cyc % 3 != 2);
    if (cyc == 20000) begin
      err_count++;
      $display("[ERR] %0t timeout", $time);
      print_verdict();
    end
  end
  always @(posedge pclk) begin
    if (presetn && power_on_reset_n && !compat) begin
      chk(video_cap_en === vs_p, "video switch");
      chk(reset_cap_en === (rs_p & cds_on), "reset switch");
    end
    if (vs_p && !video_sample_strobe) lat_n = 0;
    else lat_n++;
    if (lat_on && data_valid === 1'b1) begin
      chk(lat_n >= LAT + 1 && lat_n <= LAT + 4, "latency");
      lat_on = 0;
    end
    if (presetn && data_valid === 1'b1 && data_ready) begin
      if (data_hi === 1'b1) begin
        hi_b   = data_out;
        got_hi = 1'b1;
      end else begin
        chk(got_hi, "low byte first");
        got_hi = 1'b0;
        chk(exp_q.size() != 0, "extra word");
        if (exp_q.size() != 0) chk({hi_b, data_out} === exp_q.pop_front(), "data word");
      end
    end
    vs_p <= video_sample_strobe;
    rs_p <= reset_sample_strobe;
  end

  initial begin
    {pclk, psel, penable, pwrite, data_ready, vs_p, rs_p, got_hi, hi_b} = '0;
    {presetn, power_on_reset_n, paddr, pwdata} = '0;
    {err_count, tests_run, cyc, lat_n} = '0;
    {stall, lat_on, compat} = '0;
    cds_on = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(pready === 1'b0 && prdata === 32'h0 && data_valid === 1'b0 && data_out === 8'h00, "reset outputs");
    apb(1'b1, ADDR_CTRL, 32'h01);
    apb(1'b1, ADDR_OFFS0, 32'h11);
    power_on_reset_n <= 1'b1;
    apb(1'b0, ADDR_CTRL, 0);
    chk(d === 32'h12 && e === 1'b0, "ctrl default");
    for (int i = 0; i < NUM_CH; i++) begin
      apb(1'b0, ADDR_OFFS0 + 8'(4 * i), 0);
      chk(d === 32'h80, "offset default");
      apb(1'b0, ADDR_GAIN0 + 8'(4 * i), 0);
      chk(d === 32'h100, "gain default");
    end
    apb(1'b0, ADDR_STATUS, 0);
    chk(d[0] === 1'b1 && d[6] === 1'b0, "status after release");
    apb(1'b1, ADDR_CTRL, 32'h01);
    apb(1'b1, ADDR_SWRESET, 32'h0);
    apb(1'b0, ADDR_CTRL, 0);
    chk(d === 32'h12, "software reset");
    apb(1'b0, 8'h24, 0);
    chk(e === 1'b1 && d === 32'h0, "unmapped read");
    apb(1'b1, 8'h24, 32'hff);
    chk(e === 1'b1, "unmapped write");
    foreach (rows[i]) begin
      apb(1'b1, ADDR_CTRL, {26'h0, 2'b01, rows[i].sel, rows[i].mode});
      push_px(rows[i].mode, rows[i].sel, rows[i].r, rows[i].g, rows[i].b);
      u_ctrl.pixel(rows[i].r, rows[i].g, rows[i].b, 1'b1, 1, 2);
      drain();
    end
    lat_on = 1;
    push_px(VSTP_THREE, 2'd0, 16'h4444, 16'h5555, 16'h6666);
    u_ctrl.pixel(16'h4444, 16'h5555, 16'h6666, 1'b1, 1, 2);
    drain();
    chk(!lat_on, "no output");
    apb(1'b1, ADDR_OFFS0, 32'h81);
    apb(1'b1, ADDR_GAIN0 + 8'h04, 32'h080);
    apb(1'b1, ADDR_GAIN0 + 8'h08, 32'h1ff);
    push_px(VSTP_THREE, 2'd0, chan(16'hfff0, 8'h81, 9'h100), chan(16'h8642, 8'h80, 9'h080),
            chan(16'h9000, 8'h80, 9'h1ff));
    u_ctrl.pixel(16'hfff0, 16'h8642, 16'h9000, 1'b1, 1, 2);
    drain();
    apb(1'b1, ADDR_SWRESET, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h02);
    cds_on = 1'b0;
    for (int i = 0; i < 4; i++) begin
      push_px(VSTP_THREE, 2'd0, 16'(i), 16'(i + 16), 16'(i + 32));
      u_ctrl.pixel(16'(i), 16'(i + 16), 16'(i + 32), 1'b0, 1, PIX3_MIN_CYC - 1);
    end
    drain();
    stall = 1;
    for (int i = 0; i < 7; i++) begin
      push_px(VSTP_THREE, 2'd0, 16'(i + 64), 16'(i + 80), 16'(i + 96));
      u_ctrl.pixel(16'(i + 64), 16'(i + 80), 16'(i + 96), 1'b0, 1, 2);
    end
    repeat (10) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 0);
    chk(d[6] === 1'b1 && d[5:1] !== 5'h00, "overrun and fill");
    stall = 0;
    repeat (300) @(posedge pclk);
    exp_q.delete();
    apb(1'b1, ADDR_STATUS, 32'h40);
    apb(1'b0, ADDR_STATUS, 0);
    chk(d[6] === 1'b0 && d[5:1] === 5'h00, "drained and cleared");
    apb(1'b1, ADDR_CTRL, 32'h32);
    compat = 1;
    cds_on = 1'b1;
    push_px(VSTP_THREE, 2'd0, 16'h7777, 16'h8888, 16'h9999);
    u_ctrl.pixel(16'h7777, 16'h8888, 16'h9999, 1'b1, 2, 4);
    drain();
    print_verdict();
  end
endmodule

// ---- tb/vstp_timing_ctrl.sv ----
/*
  Timing controller model: drives both sample strobes and the three sample codes.
  Assumes pclk is the master clock; all outputs change just after rising edges.
*/
module vstp_timing_ctrl
  import vstp_pkg::*;
(
  input  wire logic         pclk,
  output logic              video_sample_strobe,
  output logic              reset_sample_strobe,
  output logic [WORD_W-1:0] red_input,
  output logic [WORD_W-1:0] green_input,
  output logic [WORD_W-1:0] blue_input
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    video_sample_strobe = 1'b0;
    reset_sample_strobe = 1'b0;
    red_input           = 16'h0000;
    green_input         = 16'h0000;
    blue_input          = 16'h0000;
  end
  // One pixel: codes valid only while the video strobe is high
  task automatic pixel(input logic [WORD_W-1:0] r, input logic [WORD_W-1:0] g, input logic [WORD_W-1:0] b,
                       input logic cds, input int hold, input int gap);
    @(posedge pclk);
    video_sample_strobe <= 1'b1;
    red_input           <= r;
    green_input         <= g;
    blue_input          <= b;
    repeat (hold) @(posedge pclk);
    video_sample_strobe <= 1'b0;
    red_input           <= ~r;
    green_input         <= ~g;
    blue_input          <= ~b;
    if (cds) begin
      @(posedge pclk);
      reset_sample_strobe <= 1'b1;
      @(posedge pclk);
      reset_sample_strobe <= 1'b0;
    end
    repeat (gap) @(posedge pclk);
  endtask
endmodule
